/* hw/fpsr_top.sv */
`timescale 1ns/100ps
`default_nettype none
// Function
// - Status 01 for corrected single-bit error
// - Status 10 for uncorrected double-bit error
// - Page-info select with read returns status
// - Bits 31..8 hold program/erase count
// - Bits 7..4 always read zero
// - Bit 3 flags count over threshold
// - Bit 2 shows JTAG read protect
// - Bit 1 shows JTAG write protect
// - Correct user key clears both protect bits in the status read
// - Bit 0 set when programmed with lock
// - Locked page refuses writes until unprotect
module fpsr_top #(
	parameter logic [fpsr_pkg::PSW_COUNT_W-1:0] COUNT_THRESHOLD = fpsr_pkg::COUNT_THRESHOLD_DEF,
	parameter logic [fpsr_pkg::KEY_W-1:0] USER_KEY = fpsr_pkg::USER_KEY_DEF
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire fpsr_pkg::fpsr_req_t req,
	input wire logic inject_sec,
	input wire logic inject_ded,
	input wire logic jtag_prot_we,
	input wire logic [fpsr_pkg::PAGE_W-1:0] jtag_prot_page,
	input wire logic jtag_rd_prot,
	input wire logic jtag_wr_prot,
	input wire logic [fpsr_pkg::KEY_W-1:0] user_key,
	output fpsr_pkg::fpsr_rsp_t rsp
);
	import fpsr_pkg::*;

	localparam int NWORDS = NUM_PAGES * WORDS_PER_PAGE;

	logic [DATA_W+1:0] mem [NWORDS];
	fpsr_page_t pages [NUM_PAGES];
	fpsr_state_t state, next_state;
	logic [DATA_W-1:0] rdata, next_rdata;
	fpsr_status_t status, next_status;
	logic rvalid, next_rvalid;
	logic refused, next_refused;
	logic [ADDR_W-1:0] raddr, next_raddr;
	logic info_rd, next_info_rd;
	logic key_ok;
	logic [PAGE_W-1:0] req_page;
	logic [PAGE_W-1:0] rd_page;
	logic wr_blocked;
	logic [DATA_W-1:0] ecc_data;
	fpsr_status_t ecc_status;
	logic [DATA_W-1:0] psw;

	assign req_page = req.addr[ADDR_W-1 -: PAGE_W];
	assign rd_page = raddr[ADDR_W-1 -: PAGE_W];
	assign key_ok = (user_key == USER_KEY);
	// Fabric writes are blocked only by the overwrite lock; JTAG protect bits never gate them
	assign wr_blocked = pages[req_page].ow_lock;

	fpsr_ecc_check i_fpsr_ecc_check (
		.raw_data(mem[raddr][DATA_W-1:0]),
		.sec_flag(mem[raddr][DATA_W]),
		.ded_flag(mem[raddr][DATA_W+1]),
		.out_data(ecc_data),
		.status(ecc_status)
	);

	always_comb begin
		psw = '0;
		psw[PSW_COUNT_LSB +: PSW_COUNT_W] = pages[rd_page].count;
		psw[PSW_RSVD_LSB +: 4] = PSW_RSVD_VALUE;
		psw[PSW_OVTH_BIT] = (pages[rd_page].count > COUNT_THRESHOLD);
		psw[PSW_RDPROT_BIT] = pages[rd_page].rd_prot && !key_ok;
		psw[PSW_WRPROT_BIT] = pages[rd_page].wr_prot && !key_ok;
		psw[PSW_OWLOCK_BIT] = pages[rd_page].ow_lock;
	end

	always_comb begin
		next_state = state;
		next_rdata = rdata;
		next_status = status;
		next_rvalid = 1'b0;
		next_refused = 1'b0;
		next_raddr = raddr;
		next_info_rd = info_rd;
		case (state)
			FPSR_IDLE: begin
				if (req.read_en) begin
					next_raddr = req.addr;
					next_info_rd = req.page_info_select;
					next_state = FPSR_READ;
				end else if (req.write_en && wr_blocked) begin
					next_refused = 1'b1;
				end
			end
			FPSR_READ: begin
				// Same data port and valid strobe for both kinds of read
				if (info_rd) begin
					next_rdata = psw;
					next_status = FPSR_ST_OK;
				end else begin
					next_rdata = ecc_data;
					next_status = ecc_status;
				end
				next_rvalid = 1'b1;
				next_state = FPSR_DONE;
			end
			FPSR_DONE: begin
				next_state = FPSR_IDLE;
			end
			default: begin
				next_state = FPSR_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= FPSR_IDLE;
			rdata <= DATA_RESET;
			status <= FPSR_ST_OK;
			rvalid <= 1'b0;
			refused <= 1'b0;
			raddr <= '0;
			info_rd <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			rdata <= next_rdata;
			status <= next_status;
			rvalid <= next_rvalid;
			refused <= next_refused;
			raddr <= next_raddr;
			info_rd <= next_info_rd;
		end
	end

	// Array contents carry no reset; page bookkeeping and the read-path registers do
	always_ff @(posedge sys_clk) begin
		if (clk_en && state == FPSR_IDLE && !req.read_en && req.write_en && !wr_blocked) begin
			mem[req.addr] <= {inject_ded, inject_sec, req.wdata};
		end
	end

	genvar gp;
	generate
		for (gp = 0; gp < NUM_PAGES; gp++) begin : g_page
			fpsr_page_t next_pg;
			logic hit;
			assign hit = (req_page == PAGE_W'(gp)) && state == FPSR_IDLE && !req.read_en;
			always_comb begin
				next_pg = pages[gp];
				if (hit && req.unprotect_en) begin
					next_pg.ow_lock = 1'b0;
				end else if (hit && (req.erase_en || (req.write_en && !wr_blocked))) begin
					// Count saturates rather than wrapping to look like a fresh page
					if (pages[gp].count != '1) begin
						next_pg.count = pages[gp].count + 1'b1;
					end
					if (req.write_en && req.overwrite_lock_request) begin
						next_pg.ow_lock = 1'b1;
					end
				end
				if (jtag_prot_we && jtag_prot_page == PAGE_W'(gp)) begin
					next_pg.rd_prot = jtag_rd_prot;
					next_pg.wr_prot = jtag_wr_prot;
				end
			end
			always_ff @(posedge sys_clk or negedge arst_n) begin
				if (!arst_n) begin
					pages[gp] <= '{count: COUNT_RESET, rd_prot: 1'b0, wr_prot: 1'b0, ow_lock: 1'b0};
				end else if (clk_en) begin
					pages[gp] <= next_pg;
				end
			end
		end
	endgenerate

	always_comb begin
		rsp.rdata = rdata;
		rsp.status = status;
		rsp.busy = (state != FPSR_IDLE);
		rsp.rvalid = rvalid;
		rsp.refused = refused;
	end

	a_rvalid_two: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_en && state == FPSR_IDLE && req.read_en) ##1 clk_en |=> rsp.rvalid)
		else $error("Read did not complete in two cycles");
	a_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(rsp.rvalid && info_rd) |-> rsp.rdata[7:4] == 4'h0)
		else $error("Reserved status bits not zero");
	a_info_ok: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(rsp.rvalid && info_rd) |-> rsp.status == FPSR_ST_OK)
		else $error("Page status read carries error code");
	a_ded_code: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_en && state == FPSR_READ && !info_rd && mem[raddr][DATA_W+1])
		|=> rsp.status == FPSR_ST_DED)
		else $error("Double error not reported");
	a_sec_code: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_en && state == FPSR_READ && !info_rd && mem[raddr][DATA_W +: 2] == 2'b01)
		|=> rsp.status == FPSR_ST_SEC)
		else $error("Single error not reported");
	a_clean_code: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_en && state == FPSR_READ && !info_rd && mem[raddr][DATA_W +: 2] == 2'b00)
		|=> rsp.status == FPSR_ST_OK)
		else $error("Clean read reported error");
	a_locked_refuse: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_en && state == FPSR_IDLE && !req.read_en && req.write_en && wr_blocked)
		|=> rsp.refused)
		else $error("Write to locked page not refused");
	a_key_lifts: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(rsp.rvalid && info_rd && $past(clk_en && key_ok)) |-> rsp.rdata[2:1] == 2'b00)
		else $error("Key did not lift protection");
	a_ovth_bit: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(rsp.rvalid && info_rd) |-> rsp.rdata[3] == (rsp.rdata[31:8] > COUNT_THRESHOLD))
		else $error("Threshold bit wrong");
	a_lock_set: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_en && state == FPSR_IDLE && !req.read_en && req.write_en && !wr_blocked
		&& req.overwrite_lock_request && !req.unprotect_en) |=> pages[$past(req_page)].ow_lock)
		else $error("Overwrite lock not recorded");

	c_info_read: cover property (@(posedge sys_clk) rsp.rvalid && info_rd);
	c_sec_read: cover property (@(posedge sys_clk) rsp.rvalid && rsp.status == FPSR_ST_SEC);
	c_ded_read: cover property (@(posedge sys_clk) rsp.rvalid && rsp.status == FPSR_ST_DED);
	c_refused: cover property (@(posedge sys_clk) rsp.refused);
endmodule
`default_nettype wire

/* hw/fpsr_pkg.sv */
package fpsr_pkg;

	localparam int ADDR_W = 8;
	localparam int PAGE_W = 4;
	localparam int NUM_PAGES = 16;
	localparam int WORDS_PER_PAGE = 16;
	localparam int DATA_W = 32;
	localparam int KEY_W = 32;

	// Page status word layout
	localparam int PSW_COUNT_LSB = 8;
	localparam int PSW_COUNT_W = 24;
	localparam int PSW_RSVD_LSB = 4;
	localparam int PSW_OVTH_BIT = 3;
	localparam int PSW_RDPROT_BIT = 2;
	localparam int PSW_WRPROT_BIT = 1;
	localparam int PSW_OWLOCK_BIT = 0;
	localparam logic [3:0] PSW_RSVD_VALUE = 4'h0;

	// Reset values
	localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
	localparam logic [PSW_COUNT_W-1:0] COUNT_RESET = 24'h00_0000;

	localparam logic [PSW_COUNT_W-1:0] COUNT_THRESHOLD_DEF = 24'h00_2710;
	localparam logic [KEY_W-1:0] USER_KEY_DEF = 32'h5a5a_a5a5;

	typedef enum logic [1:0] {
		FPSR_ST_OK = 2'h0,
		FPSR_ST_SEC = 2'h1,
		FPSR_ST_DED = 2'h2
	} fpsr_status_t;

	typedef enum logic [2:0] {
		FPSR_IDLE = 3'h1,
		FPSR_READ = 3'h2,
		FPSR_DONE = 3'h4
	} fpsr_state_t;

	typedef struct packed {
		logic read_en;
		logic write_en;
		logic erase_en;
		logic unprotect_en;
		logic page_info_select;
		logic overwrite_lock_request;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} fpsr_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		fpsr_status_t status;
		logic busy;
		logic rvalid;
		logic refused;
	} fpsr_rsp_t;

	typedef struct packed {
		logic [PSW_COUNT_W-1:0] count;
		logic rd_prot;
		logic wr_prot;
		logic ow_lock;
	} fpsr_page_t;

endpackage

/* hw/fpsr_ecc_check.sv */
`timescale 1ns/100ps
`default_nettype none
// Flags injected into a stored word stand in for the array's syndrome logic
module fpsr_ecc_check (
	input wire logic [fpsr_pkg::DATA_W-1:0] raw_data,
	input wire logic sec_flag,
	input wire logic ded_flag,
	output logic [fpsr_pkg::DATA_W-1:0] out_data,
	output fpsr_pkg::fpsr_status_t status
);
	import fpsr_pkg::*;

	always_comb begin
		out_data = raw_data;
		status = FPSR_ST_OK;
		if (ded_flag) begin
			status = FPSR_ST_DED;
		end else if (sec_flag) begin
			status = FPSR_ST_SEC;
		end
	end
endmodule
`default_nettype wire

/* testbench/fpsr_fabric_model.sv */
`timescale 1ns/100ps
`default_nettype none
module fpsr_fabric_model (
	input wire logic sys_clk,
	input wire fpsr_pkg::fpsr_rsp_t rsp,
	output fpsr_pkg::fpsr_req_t req,
	output logic inject_sec,
	output logic inject_ded
);
	import fpsr_pkg::*;
	initial begin
		req = '0;
		inject_sec = 1'b0;
		inject_ded = 1'b0;
	end
	// Released lines flip so a stale address never looks valid
	task automatic release_bus();
		req = '{addr: ~req.addr, wdata: ~req.wdata, default: 1'b0};
		inject_sec = 1'b0;
		inject_ded = 1'b0;
	endtask
	task automatic op(input fpsr_req_t r, input logic sec, input logic ded, output logic rf);
		@(negedge sys_clk);
		req = r;
		inject_sec = sec;
		inject_ded = ded;
		@(negedge sys_clk);
		rf = rsp.refused;
		release_bus();
		@(negedge sys_clk);
		rf = rf | rsp.refused;
	endtask
	task automatic rd(input logic info, input logic [ADDR_W-1:0] a,
		output logic [DATA_W-1:0] d, output logic [1:0] st, output logic ok);
		@(negedge sys_clk);
		req.read_en = 1'b1;
		req.page_info_select = info;
		req.addr = a;
		@(negedge sys_clk);
		release_bus();
		ok = 1'b0;
		for (int i = 0; i < 6 && !ok; i++) begin
			if (rsp.rvalid === 1'b1) begin
				ok = 1'b1;
				d = rsp.rdata;
				st = rsp.status;
			end else begin
				@(negedge sys_clk);
			end
		end
	endtask
endmodule
`default_nettype wire

/* testbench/flash_page_status_read_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module flash_page_status_read_bench;
	import fpsr_pkg::*;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic pwe = 1'b0;
	logic prd = 1'b0;
	logic pwr = 1'b0;
	logic cen = 1'b1;
	logic [PAGE_W-1:0] ppg = '0;
	logic [KEY_W-1:0] key = ~USER_KEY_DEF;
	logic isec;
	logic ided;
	fpsr_req_t req;
	fpsr_rsp_t rsp;
	int bad_count = 0;
	int samples_checked = 0;
	always #4 sys_clk = ~sys_clk;
	// Threshold of 2 keeps the over-count boundary reachable in a few writes
	fpsr_top #(.COUNT_THRESHOLD(24'h00_0002)) i_fpsr_top (.sys_clk(sys_clk), .arst_n(arst_n),
		.clk_en(cen), .req(req), .inject_sec(isec), .inject_ded(ided), .jtag_prot_we(pwe),
		.jtag_prot_page(ppg), .jtag_rd_prot(prd), .jtag_wr_prot(pwr), .user_key(key), .rsp(rsp));
	fpsr_fabric_model i_fpsr_fabric_model (.sys_clk(sys_clk), .rsp(rsp), .req(req),
		.inject_sec(isec), .inject_ded(ided));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic info, input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] s);
		logic [31:0] gd;
		logic [1:0] gs;
		logic ok;
		i_fpsr_fabric_model.rd(info, a, gd, gs, ok);
		chk({31'h0, ok}, 32'h1);
		chk(gd, d);
		chk({30'h0, gs}, {30'h0, s});
		// Answer cycle still busy, then idle with the valid pulse gone
		chk({31'h0, rsp.busy}, 32'h1);
		@(negedge sys_clk);
		chk({30'h0, rsp.busy, rsp.rvalid}, 32'h0);
	endtask
	// Flags: write, erase, unprotect, lock
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] f,
		input logic [1:0] e, input logic xr);
		logic r;
		i_fpsr_fabric_model.op('{1'b0, f[3], f[2], f[1], 1'b0, f[0], a, d}, e[0], e[1], r);
		chk({31'h0, r}, {31'h0, xr});
	endtask
	task automatic prot(input logic [3:0] pg, input logic r, input logic w);
		@(negedge sys_clk);
		pwe = 1'b1;
		ppg = pg;
		prd = r;
		pwr = w;
		@(negedge sys_clk);
		pwe = 1'b0;
	endtask
	task automatic t_data();
		wr(8'h00, 32'h1234_5678, 4'h8, 2'h0, 1'b0);
		wr(8'h01, 32'hcafe_0001, 4'h8, 2'h1, 1'b0);
		wr(8'h02, 32'h0bad_f00d, 4'h8, 2'h2, 1'b0);
		rchk(1'b0, 8'h00, 32'h1234_5678, 2'h0);
		rchk(1'b0, 8'h01, 32'hcafe_0001, 2'h1);
		rchk(1'b0, 8'h02, 32'h0bad_f00d, 2'h2);
		$display("data status test done");
	endtask
	task automatic t_count();
		wr(8'h10, 32'h1, 4'h8, 2'h0, 1'b0);
		wr(8'h11, 32'h2, 4'h8, 2'h0, 1'b0);
		wr(8'h12, 32'h0, 4'h4, 2'h0, 1'b0);
		wr(8'h40, 32'h3, 4'h8, 2'h0, 1'b0);
		wr(8'h41, 32'h4, 4'h8, 2'h0, 1'b0);
		rchk(1'b1, 8'h10, 32'h0000_0308, 2'h0);
		rchk(1'b1, 8'h4f, 32'h0000_0200, 2'h0);
		$display("count test done");
	endtask
	task automatic t_prot();
		prot(4'h2, 1'b1, 1'b0);
		prot(4'h6, 1'b0, 1'b1);
		rchk(1'b1, 8'h20, 32'h0000_0004, 2'h0);
		rchk(1'b1, 8'h60, 32'h0000_0002, 2'h0);
		key = USER_KEY_DEF;
		rchk(1'b1, 8'h20, 32'h0, 2'h0);
		rchk(1'b1, 8'h60, 32'h0, 2'h0);
		key = ~USER_KEY_DEF;
		$display("protect test done");
	endtask
	task automatic t_lock();
		wr(8'h30, 32'h5555_aaaa, 4'h9, 2'h0, 1'b0);
		rchk(1'b1, 8'h30, 32'h0000_0101, 2'h0);
		wr(8'h31, 32'h1111_2222, 4'h8, 2'h0, 1'b1);
		rchk(1'b1, 8'h30, 32'h0000_0101, 2'h0);
		wr(8'h30, 32'h0, 4'h2, 2'h0, 1'b0);
		wr(8'h31, 32'h1111_2222, 4'h8, 2'h0, 1'b0);
		rchk(1'b0, 8'h31, 32'h1111_2222, 2'h0);
		rchk(1'b1, 8'h30, 32'h0000_0200, 2'h0);
		$display("lock test done");
	endtask
	// A write issued while the enable is low must leave the page count untouched
	task automatic t_freeze();
		cen = 1'b0;
		wr(8'h50, 32'h7777_8888, 4'h8, 2'h0, 1'b0);
		cen = 1'b1;
		rchk(1'b1, 8'h50, 32'h0, 2'h0);
		$display("freeze test done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		arst_n = 1'b1;
		t_data();
		t_count();
		t_prot();
		t_lock();
		t_freeze();
		tally_and_finish();
	end
	// About 100 cycles of traffic; far more is allowed before giving up
	initial begin
		#40000;
		bad_count++;
		$display("[ERR] %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule
`default_nettype wire
